//--- include/dpr_pkg.sv
/*
 * Constants, field positions, command codes and carrier types of the
 * DMA programming and read-back port.
 * Assumes one 10 MHz system clock and an active-low asynchronous reset.
 */
// Operation
// - Host input cycles to the port return read-back register contents.
// - Reads run status, byte count lo/hi, port A lo/hi, port B lo/hi.
// - Registers excluded by the read mask are skipped.
// - Initiate-read or read-status command restarts the masked sequence.
// - Load copies start address only into the source port counter.
// - Each block moves one byte more than the block length.
// - Transfer group bits 3..6 announce address and length bytes.
// - Port A group: bit 3 I/O, bit 4 increment, 5 fixed, 6 timing.
// - Port B group decodes the same fields as port A.
// - Mode group: bits 6..5 mode, 4 interrupt, 3 and 2 port B bytes.
// - Ready group: bit 3 ready high, 4 wait states, 5 auto restart.
// - Command CF loads source counter and clears the byte counter.
// - Command 87 enables transfers.
// - Every written byte other than command 87 disables the device until enabled again.
// - Reset leaves the device disabled with no transfers.
package dpr_pkg;
   localparam logic [7:0] CMD_LOAD = 8'hCF;
   localparam logic [7:0] CMD_ENABLE = 8'h87;
   localparam logic [7:0] CMD_INIT_RD = 8'hA7;
   localparam logic [7:0] CMD_RD_STAT = 8'hBF;
   localparam logic [7:0] CMD_SET_MASK = 8'hBB;
   localparam logic [7:0] CMD_RESET = 8'hC3;
   localparam logic [2:0] GRP_A_CFG = 3'h4;
   localparam logic [2:0] GRP_B_CFG = 3'h0;
   localparam logic [2:0] GRP_RDY = 3'h2;
   localparam logic [1:0] GRP_XFER = 2'h1;
   localparam logic [1:0] GRP_MODE = 2'h1;
   localparam logic [1:0] GRP_CMD = 2'h3;
   localparam logic [1:0] GRP_MATCH = 2'h0;
   localparam int B_HI = 7;
   localparam int B_DIR = 2;
   localparam int B_IO = 3;
   localparam int B_INC = 4;
   localparam int B_FIX = 5;
   localparam int B_TIM = 6;
   localparam int B_RDYH = 3;
   localparam int B_WAIT = 4;
   localparam int B_AUTO = 5;
   localparam int PEND_W = 9;
   localparam logic [3:0] P_PAL = 4'h0;
   localparam logic [3:0] P_PAH = 4'h1;
   localparam logic [3:0] P_BLL = 4'h2;
   localparam logic [3:0] P_BLH = 4'h3;
   localparam logic [3:0] P_PBL = 4'h4;
   localparam logic [3:0] P_PBH = 4'h5;
   localparam logic [3:0] P_DR0 = 4'h6;
   localparam logic [3:0] P_DR1 = 4'h7;
   localparam logic [3:0] P_MSK = 4'h8;
   localparam logic [2:0] RB_STAT = 3'h0;
   localparam logic [2:0] RB_LAST = 3'h6;
   localparam logic [6:0] RMASK_RST = 7'h7F;
   localparam logic [15:0] ADDR_RST = 16'h0000;
   localparam logic [1:0] MODE_RST = 2'h0;

   typedef struct packed {
      logic io;
      logic fixed;
      logic inc;
   } dpr_port_mode_type;

   typedef struct packed {
      logic cs_n;
      logic iorq_n;
      logic rd_n;
      logic wr_n;
      logic rdy;
      logic [7:0] data;
   } dpr_host_type;

   localparam dpr_port_mode_type PMODE_RST = 3'h1;
   localparam dpr_host_type HOST_RST = 13'h1E00;
endpackage : dpr_pkg

//--- rtl/dpr_readback_port.sv
/*
 * Programming decoder, read-back sequencer and simple transfer counter
 * of a single-channel DMA controller addressed as an I/O port.
 * Assumes host pins are asynchronous and held for several clock cycles.
 */
`timescale 1ns/1ps
module dpr_readback_port (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic cs_n_i,
   input wire logic iorq_n_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic [7:0] data_i,
   input wire logic ready_i,
   output logic [7:0] data_o,
   output logic data_oe_o,
   output logic enabled_o,
   output logic xfer_o,
   output logic a_to_b_o,
   output logic [1:0] xfer_mode_o,
   output logic wait_en_o,
   output logic [15:0] port_a_addr_o,
   output logic [15:0] port_b_addr_o
);

   // ==========================================================
   // Helpers
   function automatic logic [2:0] next_idx(input logic [2:0] cur,
                                          input logic [6:0] mask);
      logic [2:0] idx;
      logic found;
      next_idx = cur;
      idx = cur;
      found = 1'b0;
      for (int i = 0; i < 7; i++) begin
         idx = (idx == dpr_pkg::RB_LAST) ? 3'h0 : 3'(idx + 3'h1);
         if (mask[idx] && !found) begin
            next_idx = idx;
            found = 1'b1;
         end
      end
   endfunction : next_idx

   function automatic logic [15:0] step(input logic [15:0] a,
                                        input dpr_pkg::dpr_port_mode_type m);
      if (m.fixed) begin
         step = a;
      end else if (m.inc) begin
         step = a + 16'h0001;
      end else begin
         step = a - 16'h0001;
      end
   endfunction : step

   function automatic logic [3:0] low_bit(input logic [8:0] p);
      low_bit = 4'h0;
      for (int i = dpr_pkg::PEND_W - 1; i >= 0; i--) begin
         if (p[i]) begin
            low_bit = 4'(i);
         end
      end
   endfunction : low_bit

   // ==========================================================
   // Pin synchronisers
   dpr_pkg::dpr_host_type s1;
   dpr_pkg::dpr_host_type s2;
   logic wr_prev;
   logic rd_prev;
   logic wr_act;
   logic rd_act;
   logic wr_stb;
   logic rd_beg;
   logic rd_end;
   logic [7:0] wdat;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1 <= dpr_pkg::HOST_RST;
         s2 <= dpr_pkg::HOST_RST;
         wr_prev <= 1'b0;
         rd_prev <= 1'b0;
      end else begin
         s1 <= '{cs_n_i, iorq_n_i, rd_n_i, wr_n_i, ready_i, data_i};
         s2 <= s1;
         wr_prev <= wr_act;
         rd_prev <= rd_act;
      end
   end

   assign wr_act = !s2.cs_n && !s2.iorq_n && !s2.wr_n;
   assign rd_act = !s2.cs_n && !s2.iorq_n && !s2.rd_n;
   // Data is taken in the same cycle as the strobe settles, so it has had the
   // same two-stage settling as the strobe itself.
   assign wr_stb = wr_act && !wr_prev;
   assign rd_beg = rd_act && !rd_prev;
   assign rd_end = !rd_act && rd_prev;
   assign wdat = s2.data;

   // ==========================================================
   // Programming, read-back and transfer state
   logic enabled, next_enabled, xfer, next_xfer, dir, next_dir;
   logic rdy_high, next_rdy_high, wait_en, next_wait_en;
   logic auto_rs, next_auto_rs, end_blk, next_end_blk;
   logic xferred, next_xferred, oe, next_oe;
   logic [1:0] mode, next_mode;
   logic [15:0] pa_start, next_pa_start, pb_start, next_pb_start;
   logic [15:0] pa_cnt, next_pa_cnt, pb_cnt, next_pb_cnt;
   logic [15:0] blk_len, next_blk_len, byte_cnt, next_byte_cnt;
   dpr_pkg::dpr_port_mode_type pa_mode, next_pa_mode;
   dpr_pkg::dpr_port_mode_type pb_mode, next_pb_mode;
   logic [8:0] pend, next_pend;
   logic [6:0] rmask, next_rmask;
   logic [2:0] ptr, next_ptr;
   logic [7:0] rdata, next_rdata, rb, status;
   logic rdy_act;

   assign rdy_act = (s2.rdy == rdy_high);
   assign status = {2'b00, !end_blk, 3'b000, rdy_act, xferred};

   always_comb begin
      unique case (ptr)
         3'h0: rb = status;
         3'h1: rb = byte_cnt[7:0];
         3'h2: rb = byte_cnt[15:8];
         3'h3: rb = pa_cnt[7:0];
         3'h4: rb = pa_cnt[15:8];
         3'h5: rb = pb_cnt[7:0];
         3'h6: rb = pb_cnt[15:8];
         default: rb = 8'h00;
      endcase
   end

   always_comb begin
      next_enabled = enabled;
      next_xfer = 1'b0;
      next_dir = dir;
      next_rdy_high = rdy_high;
      next_wait_en = wait_en;
      next_auto_rs = auto_rs;
      next_end_blk = end_blk;
      next_xferred = xferred;
      next_mode = mode;
      next_pa_start = pa_start;
      next_pb_start = pb_start;
      next_pa_cnt = pa_cnt;
      next_pb_cnt = pb_cnt;
      next_blk_len = blk_len;
      next_byte_cnt = byte_cnt;
      next_pa_mode = pa_mode;
      next_pb_mode = pb_mode;
      next_pend = pend;
      next_rmask = rmask;
      next_ptr = ptr;
      next_oe = rd_act;
      next_rdata = rd_beg ? rb : rdata;
      if (rd_end) begin
         next_ptr = next_idx(ptr, rmask);
      end
      if (wr_stb) begin
         next_enabled = 1'b0;
         if (pend != '0) begin
            next_pend[low_bit(pend)] = 1'b0;
            unique case (low_bit(pend))
               dpr_pkg::P_PAL: next_pa_start[7:0] = wdat;
               dpr_pkg::P_PAH: next_pa_start[15:8] = wdat;
               dpr_pkg::P_BLL: next_blk_len[7:0] = wdat;
               dpr_pkg::P_BLH: next_blk_len[15:8] = wdat;
               dpr_pkg::P_PBL: next_pb_start[7:0] = wdat;
               dpr_pkg::P_PBH: next_pb_start[15:8] = wdat;
               dpr_pkg::P_MSK: next_rmask = wdat[6:0];
               default: ;
            endcase
         end else if (!wdat[dpr_pkg::B_HI]) begin
            if (wdat[2:0] == dpr_pkg::GRP_A_CFG) begin
               next_pa_mode = '{wdat[dpr_pkg::B_IO], wdat[dpr_pkg::B_FIX],
                                wdat[dpr_pkg::B_INC]};
               next_pend[dpr_pkg::P_DR0] = wdat[dpr_pkg::B_TIM];
            end else if (wdat[2:0] == dpr_pkg::GRP_B_CFG) begin
               next_pb_mode = '{wdat[dpr_pkg::B_IO], wdat[dpr_pkg::B_FIX],
                                wdat[dpr_pkg::B_INC]};
               next_pend[dpr_pkg::P_DR0] = wdat[dpr_pkg::B_TIM];
            end else begin
               // Search codes leave the direction unchanged, as only transfer codes set it; their trailing
               // bytes are still consumed so the stream stays in step.
               if (wdat[1:0] == dpr_pkg::GRP_XFER) begin
                  next_dir = wdat[dpr_pkg::B_DIR];
               end
               next_pend[3:0] = wdat[6:3];
            end
         end else if (wdat[1:0] == dpr_pkg::GRP_MODE) begin
            next_mode = wdat[6:5];
            next_pend[dpr_pkg::P_PBL] = wdat[2];
            next_pend[dpr_pkg::P_PBH] = wdat[3];
            next_pend[dpr_pkg::P_DR1] = wdat[4];
         end else if (wdat[2:0] == dpr_pkg::GRP_RDY) begin
            next_rdy_high = wdat[dpr_pkg::B_RDYH];
            next_wait_en = wdat[dpr_pkg::B_WAIT];
            next_auto_rs = wdat[dpr_pkg::B_AUTO];
         end else if (wdat[1:0] == dpr_pkg::GRP_MATCH) begin
            next_pend[dpr_pkg::P_DR0] = wdat[3];
            next_pend[dpr_pkg::P_DR1] = wdat[4];
         end else begin
            unique case (wdat)
               dpr_pkg::CMD_LOAD: begin
                  if (dir) begin
                     next_pa_cnt = pa_start;
                  end else begin
                     next_pb_cnt = pb_start;
                  end
                  next_byte_cnt = '0;
                  next_end_blk = 1'b0;
                  next_xferred = 1'b0;
               end
               dpr_pkg::CMD_ENABLE: next_enabled = 1'b1;
               dpr_pkg::CMD_INIT_RD,
               dpr_pkg::CMD_RD_STAT: begin
                  next_ptr = next_idx(dpr_pkg::RB_LAST, rmask);
               end
               dpr_pkg::CMD_SET_MASK: next_pend[dpr_pkg::P_MSK] = 1'b1;
               dpr_pkg::CMD_RESET: begin
                  next_rdy_high = 1'b0;
                  next_wait_en = 1'b0;
                  next_auto_rs = 1'b0;
                  next_pend = '0;
               end
               default: ;
            endcase
         end
      end else if (enabled && rdy_act) begin
         next_xfer = 1'b1;
         next_xferred = 1'b1;
         next_pa_cnt = step(pa_cnt, pa_mode);
         next_pb_cnt = step(pb_cnt, pb_mode);
         next_byte_cnt = byte_cnt + 16'h0001;
         // The byte whose count equals the length is the last, giving
         // length plus one bytes per block.
         if (byte_cnt == blk_len) begin
            next_end_blk = 1'b1;
            if (auto_rs) begin
               next_pa_cnt = pa_start;
               next_pb_cnt = pb_start;
               next_byte_cnt = '0;
            end else begin
               next_enabled = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         enabled <= 1'b0;
         xfer <= 1'b0;
         dir <= 1'b1;
         rdy_high <= 1'b0;
         wait_en <= 1'b0;
         auto_rs <= 1'b0;
         end_blk <= 1'b0;
         xferred <= 1'b0;
         oe <= 1'b0;
         mode <= dpr_pkg::MODE_RST;
         pa_start <= dpr_pkg::ADDR_RST;
         pb_start <= dpr_pkg::ADDR_RST;
         pa_cnt <= dpr_pkg::ADDR_RST;
         pb_cnt <= dpr_pkg::ADDR_RST;
         blk_len <= dpr_pkg::ADDR_RST;
         byte_cnt <= dpr_pkg::ADDR_RST;
         pa_mode <= dpr_pkg::PMODE_RST;
         pb_mode <= dpr_pkg::PMODE_RST;
         pend <= '0;
         rmask <= dpr_pkg::RMASK_RST;
         ptr <= dpr_pkg::RB_STAT;
         rdata <= 8'h00;
      end else begin
         enabled <= next_enabled;
         xfer <= next_xfer;
         dir <= next_dir;
         rdy_high <= next_rdy_high;
         wait_en <= next_wait_en;
         auto_rs <= next_auto_rs;
         end_blk <= next_end_blk;
         xferred <= next_xferred;
         oe <= next_oe;
         mode <= next_mode;
         pa_start <= next_pa_start;
         pb_start <= next_pb_start;
         pa_cnt <= next_pa_cnt;
         pb_cnt <= next_pb_cnt;
         blk_len <= next_blk_len;
         byte_cnt <= next_byte_cnt;
         pa_mode <= next_pa_mode;
         pb_mode <= next_pb_mode;
         pend <= next_pend;
         rmask <= next_rmask;
         ptr <= next_ptr;
         rdata <= next_rdata;
      end
   end

   assign data_o = rdata;
   assign data_oe_o = oe;
   assign enabled_o = enabled;
   assign xfer_o = xfer;
   assign a_to_b_o = dir;
   assign xfer_mode_o = mode;
   assign wait_en_o = wait_en;
   assign port_a_addr_o = pa_cnt;
   assign port_b_addr_o = pb_cnt;

   // ==========================================================
   // Assertions
   logic cmd_ok;
   assign cmd_ok = wr_stb && pend == '0;

   property p_rd_data;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      rd_beg |=> data_oe_o && data_o == $past(rb);
   endproperty
   a_rd_data: assert property (p_rd_data)
      else $error("read data not presented");

   property p_order;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      rd_end && !wr_stb |=> ptr == next_idx($past(ptr), $past(rmask));
   endproperty
   a_order: assert property (p_order)
      else $error("read pointer out of order");

   property p_mask;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      rd_end && !wr_stb && rmask != '0 |=> rmask[ptr];
   endproperty
   a_mask: assert property (p_mask)
      else $error("pointer on masked register");

   property p_init;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      cmd_ok && (wdat == dpr_pkg::CMD_INIT_RD || wdat == dpr_pkg::CMD_RD_STAT)
      |=> ptr == next_idx(dpr_pkg::RB_LAST, rmask);
   endproperty
   a_init: assert property (p_init)
      else $error("read sequence not restarted");

   property p_load;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      cmd_ok && wdat == dpr_pkg::CMD_LOAD && dir
      |=> pa_cnt == $past(pa_start) && $stable(pb_cnt) && byte_cnt == '0;
   endproperty
   a_load: assert property (p_load)
      else $error("load touched wrong counter");

   property p_blk;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      enabled && rdy_act && !wr_stb && !auto_rs && byte_cnt == blk_len
      |=> !enabled_o ##1 !xfer_o;
   endproperty
   a_blk: assert property (p_blk)
      else $error("block did not stop after length plus one");

   property p_en;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      cmd_ok && wdat == dpr_pkg::CMD_ENABLE |=> enabled_o;
   endproperty
   a_en: assert property (p_en)
      else $error("enable command ignored");

   property p_dis;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      wr_stb && !(pend == '0 && wdat == dpr_pkg::CMD_ENABLE)
      |=> !enabled_o ##1 !xfer_o;
   endproperty
   a_dis: assert property (p_dis)
      else $error("write did not disable");

   property p_idle;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      xfer_o |-> $past(enabled);
   endproperty
   a_idle: assert property (p_idle)
      else $error("transfer while disabled");

   c_rd: cover property (@(posedge sys_clk_i) rd_end ##[1:40] rd_end);
   c_load: cover property (@(posedge sys_clk_i)
                           cmd_ok && wdat == dpr_pkg::CMD_LOAD);
   c_blk: cover property (@(posedge sys_clk_i) xfer_o ##1 !enabled_o);
   c_wrap: cover property (@(posedge sys_clk_i)
                           rd_end ##1 ptr == dpr_pkg::RB_STAT);
endmodule : dpr_readback_port

//--- sim/dpr_host_model.sv
/*
 * Behavioural host processor that programs and reads the DMA port with
 * I/O output and input cycles, and drives the peripheral ready line.
 * Assumes the bench calls its tasks from one process at a time.
 */
`timescale 1ns/1ps
module dpr_host_model (
   input wire logic sys_clk_i,
   input wire logic [7:0] rd_data_i,
   input wire logic rd_oe_i,
   output dpr_pkg::dpr_host_type bus_o
);
   initial begin
      bus_o = dpr_pkg::HOST_RST;
   end

   // ==========================================================
   // Pin sequencing
   task automatic strobe(input logic rd, input logic wr);
      bus_o.cs_n = rd & wr;
      bus_o.iorq_n = rd & wr;
      bus_o.rd_n = rd;
      bus_o.wr_n = wr;
   endtask : strobe

   task automatic set_rdy(input logic r);
      @(negedge sys_clk_i);
      bus_o.rdy = r;
   endtask : set_rdy

   // Data is held four edges, past the three the port needs to take it.
   // Once released the bus shows the inverse, never the stale byte.
   task automatic write_byte(input logic [7:0] b);
      @(negedge sys_clk_i);
      bus_o.data = b;
      strobe(1'b1, 1'b0);
      repeat (4) @(negedge sys_clk_i);
      strobe(1'b1, 1'b1);
      bus_o.data = ~b;
      repeat (4) @(negedge sys_clk_i);
   endtask : write_byte

   task automatic read_byte(output logic [7:0] b, output logic ok);
      @(negedge sys_clk_i);
      strobe(1'b0, 1'b1);
      repeat (5) @(negedge sys_clk_i);
      ok = rd_oe_i;
      b = rd_data_i;
      strobe(1'b1, 1'b1);
      repeat (5) @(negedge sys_clk_i);
   endtask : read_byte
endmodule : dpr_host_model

//--- sim/dpr_readback_port_tb_top.sv
/*
 * Self-checking bench: programs a fixed-destination block transfer,
 * counts the bytes moved and reads the counters back through masks.
 * Assumes the host model drives all bus pins at falling clock edges.
 */
`timescale 1ns/1ps
module dpr_readback_port_tb_top;
   logic sys_clk;
   logic nrst;
   dpr_pkg::dpr_host_type hbus;
   logic [7:0] data_o;
   logic data_oe;
   logic enabled;
   logic xfer;
   logic a_to_b;
   logic [1:0] xfer_mode;
   logic wait_en;
   logic [15:0] pa;
   logic [15:0] pb;
   int failures = 0;
   int n_compared = 0;
   int n_xfer = 0;
   logic [7:0] prog [11] = '{8'h79, 8'h50, 8'h10, 8'h03, 8'h00, 8'h14,
      8'h28, 8'hC5, 8'h05, 8'h8A, dpr_pkg::CMD_LOAD};

   dpr_host_model u_host (
      .sys_clk_i(sys_clk),
      .rd_data_i(data_o),
      .rd_oe_i(data_oe),
      .bus_o(hbus)
   );

   dpr_readback_port u_dut (
      .sys_clk_i(sys_clk),
      .nrst_i(nrst),
      .cs_n_i(hbus.cs_n),
      .iorq_n_i(hbus.iorq_n),
      .rd_n_i(hbus.rd_n),
      .wr_n_i(hbus.wr_n),
      .data_i(hbus.data),
      .ready_i(hbus.rdy),
      .data_o(data_o),
      .data_oe_o(data_oe),
      .enabled_o(enabled),
      .xfer_o(xfer),
      .a_to_b_o(a_to_b),
      .xfer_mode_o(xfer_mode),
      .wait_en_o(wait_en),
      .port_a_addr_o(pa),
      .port_b_addr_o(pb)
   );

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      if (xfer === 1'b1) begin
         n_xfer++;
      end
   end

   // ==========================================================
   // Comparison and access helpers
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic rd_chk(input logic [7:0] exp, input logic [7:0] care);
      logic [7:0] b;
      logic ok;
      u_host.read_byte(b, ok);
      check("read drive", {15'h0000, ok}, 16'h0001);
      check("read byte", {8'h00, b & care}, {8'h00, exp & care});
   endtask : rd_chk

   task automatic close_out;
      if (failures == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out

   // ==========================================================
   // Watchdog
   // The whole sequence needs well under 2000 cycles.
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      close_out();
   end

   // ==========================================================
   // Test sequence
   initial begin
      nrst = 1'b0;
      repeat (20) @(negedge sys_clk);
      check("enabled", {15'h0000, enabled}, 16'h0000);
      check("a_to_b", {15'h0000, a_to_b}, 16'h0001);
      check("pa", pa, 16'h0000);
      check("oe", {15'h0000, data_oe}, 16'h0000);
      nrst = 1'b1;
      u_host.set_rdy(1'b1);
      // Port B is loaded first as temporary source, then A.
      for (int i = 0; i < 11; i++) begin
         u_host.write_byte(prog[i]);
      end
      check("a_to_b", {15'h0000, a_to_b}, 16'h0000);
      check("pb", pb, 16'h0005);
      check("pa", pa, 16'h0000);
      check("mode", {14'h0000, xfer_mode}, 16'h0002);
      check("wait", {15'h0000, wait_en}, 16'h0000);
      check("enabled", {15'h0000, enabled}, 16'h0000);
      u_host.write_byte(8'h05);
      check("a_to_b", {15'h0000, a_to_b}, 16'h0001);
      u_host.write_byte(dpr_pkg::CMD_LOAD);
      check("pa", pa, 16'h1050);
      check("pb", pb, 16'h0005);
      n_xfer = 0;
      u_host.write_byte(dpr_pkg::CMD_ENABLE);
      for (int i = 0; i < 200 && enabled !== 1'b0; i++) begin
         @(negedge sys_clk);
      end
      check("bytes moved", 16'(n_xfer), 16'h0004);
      check("enabled", {15'h0000, enabled}, 16'h0000);
      check("pa", pa, 16'h1054);
      check("pb", pb, 16'h0005);
      // Full read-back sequence, started as the host must after reset.
      u_host.write_byte(dpr_pkg::CMD_INIT_RD);
      rd_chk(8'h03, 8'hFF);
      rd_chk(8'h04, 8'hFF);
      rd_chk(8'h00, 8'hFF);
      rd_chk(8'h54, 8'hFF);
      rd_chk(8'h10, 8'hFF);
      rd_chk(8'h05, 8'hFF);
      rd_chk(8'h00, 8'hFF);
      // Only the port A counter bytes left in the mask.
      u_host.write_byte(dpr_pkg::CMD_SET_MASK);
      u_host.write_byte(8'h18);
      u_host.write_byte(dpr_pkg::CMD_INIT_RD);
      rd_chk(8'h54, 8'hFF);
      rd_chk(8'h10, 8'hFF);
      rd_chk(8'h54, 8'hFF);
      rd_chk(8'h10, 8'hFF);
      // Port B bytes only: without a restart the pointer would stay on
      // the port A low byte, which the new mask leaves out.
      u_host.write_byte(dpr_pkg::CMD_SET_MASK);
      u_host.write_byte(8'h60);
      u_host.write_byte(dpr_pkg::CMD_RD_STAT);
      rd_chk(8'h05, 8'hFF);
      rd_chk(8'h00, 8'hFF);
      // Ready low while active-high polarity: enabled but idle.
      u_host.set_rdy(1'b0);
      n_xfer = 0;
      u_host.write_byte(dpr_pkg::CMD_ENABLE);
      check("enabled", {15'h0000, enabled}, 16'h0001);
      repeat (20) @(negedge sys_clk);
      check("bytes idle", 16'(n_xfer), 16'h0000);
      u_host.write_byte(8'h9A);
      check("enabled", {15'h0000, enabled}, 16'h0000);
      check("wait", {15'h0000, wait_en}, 16'h0001);
      u_host.write_byte(dpr_pkg::CMD_RESET);
      check("wait", {15'h0000, wait_en}, 16'h0000);
      close_out();
   end
endmodule : dpr_readback_port_tb_top
